// [src/rcg_pkg.sv]
`default_nettype none
package rcg_pkg;

  // ---------------------------------------------------------------
  // Register map, byte offsets inside the system control block
  // ---------------------------------------------------------------
  localparam logic [31:0] SCB_BASE         = 32'h400fe000;
  localparam logic [11:0] OFS_RUN_CLOCK_CFG = 12'h060;
  localparam logic [11:0] OFS_RUN_GATE_1   = 12'h104;
  localparam logic [11:0] OFS_SLEEP_GATE_1 = 12'h114;
  localparam logic [11:0] OFS_DSLEEP_GATE_1 = 12'h124;
  localparam logic [11:0] OFS_IRQ_STATUS   = 12'h200;
  localparam logic [11:0] OFS_IRQ_MASK     = 12'h204;

  // ---------------------------------------------------------------
  // Field positions of the gating registers
  // ---------------------------------------------------------------
  localparam int BIT_COMPARATOR_2 = 26;
  localparam int BIT_COMPARATOR_1 = 25;
  localparam int BIT_COMPARATOR_0 = 24;
  localparam int BIT_GP_TIMER_3   = 19;
  localparam int BIT_GP_TIMER_2   = 18;
  localparam int BIT_GP_TIMER_1   = 17;
  localparam int BIT_GP_TIMER_0   = 16;
  localparam int BIT_TWO_WIRE_1   = 14;
  localparam int BIT_TWO_WIRE_0   = 12;
  localparam int BIT_QUAD_ENC_0   = 8;
  localparam int BIT_SYNC_SER_1   = 5;
  localparam int BIT_SYNC_SER_0   = 4;
  localparam int BIT_ASYNC_SER_2  = 2;
  localparam int BIT_ASYNC_SER_1  = 1;
  localparam int BIT_ASYNC_SER_0  = 0;

  // Writable gating bits; everything else reads zero
  localparam logic [31:0] GATE_WRITABLE    = 32'h070f5137;
  localparam logic [31:0] GATE_RESET       = 32'h00000000;

  // Run clock configuration: only the auto gating select lives here
  localparam int          BIT_AUTO_CLK_GATE = 27;
  localparam logic [31:0] RCC_WRITABLE     = 32'h08000000;
  localparam logic [31:0] RCC_RESET        = 32'h00000000;
  localparam logic [31:0] IRQ_RESET        = 32'h00000000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RCG_PM_RUN    = 2'b00,
    RCG_PM_SLEEP  = 2'b01,
    RCG_PM_DSLEEP = 2'b10
  } rcg_pmode_e;

  typedef enum logic [1:0] {
    RCG_APB_IDLE = 2'b00,
    RCG_APB_CAPT = 2'b01,
    RCG_APB_RESP = 2'b10
  } rcg_apb_e;

endpackage : rcg_pkg
`default_nettype wire

// [src/rcg_gate_if.sv]
`default_nettype none
interface rcg_gate_if (
  input wire logic sys_clk
);
  logic [31:0] clk_en;
  logic [31:0] gated_clk;

  modport ctrl (output clk_en, input gated_clk);
  modport gate (input sys_clk, input clk_en, output gated_clk);
endinterface : rcg_gate_if
`default_nettype wire

// [src/rcg_clk_gate.sv]
`default_nettype none
module rcg_clk_gate #(
  parameter logic [31:0] UNIT_MAP = 32'h070f5137
) (
  rcg_gate_if.gate gif
);

  // ---------------------------------------------------------------
  // Latch-based gating cells, one per mapped unit
  // ---------------------------------------------------------------
  // Enable is only transparent while the clock is low, so a change
  // can never cut a high phase short.
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_cell
      if (UNIT_MAP[i]) begin : g_on
        logic en_lat;
        always_latch begin
          if (!gif.sys_clk) begin
            en_lat = gif.clk_en[i];
          end
        end
        assign gif.gated_clk[i] = gif.sys_clk & en_lat;
      end else begin : g_off
        assign gif.gated_clk[i] = 1'b0;
      end
    end
  endgenerate

endmodule : rcg_clk_gate
`default_nettype wire

// [src/rcg_top.sv]
// Functional notes
// - Set gating bit clocks its unit; cleared bit leaves unit unclocked and disabled.
// - Any access to a unit whose clock is off answers with a bus fault.
// - Run gating register resets to all zeros, every unit off.
// - Run gating register decodes at offset 0x104 in the control block.
// - Run register governs while running; sleep and deep-sleep registers govern low power.
// - Sleep registers apply only when auto clock gating select is set.
// - Bits 26, 25, 24 gate comparators 2, 1, 0; read/write, reset zero.
// - Bits 19 to 16 gate timers 3 to 0; read/write, reset zero.
// - Bit 14 gates two-wire module 1, bit 12 module 0.
// - Bit 8 gates quadrature encoder 0; read/write, reset zero.
// - Reserved bits are read-only zero; software preserves them.
// - Bits 5 and 4 gate synchronous serial modules 1 and 0.
// - Bits 2, 1, 0 gate async serial 2, 1, 0; bit 3 reserved.
// - Sleep gating register, same layout, zero reset, sits at offset 0x114.
`default_nettype none
module rcg_top
  import rcg_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // APB register slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Processor power state
  input  wire logic        core_sleep,
  input  wire logic        core_deep_sleep,
  // Peripheral access filter, one select bit per unit position
  input  wire logic [31:0] unit_sel,
  input  wire logic        unit_enable,
  output logic      [31:0] unit_sel_gated,
  output logic             unit_fault,
  // Gated clocks and enables to the units
  output logic      [31:0] unit_clk,
  output logic      [31:0] unit_clk_en,
  // Interrupt
  output logic             irq
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  // Assert is immediate; release waits two edges so no flop leaves reset mid-edge
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] run_gate_reg_1_r;
  logic [31:0] sleep_gate_reg_1_r;
  logic [31:0] deep_sleep_gate_reg_1_r;
  logic [31:0] run_clock_config_reg_r;
  logic [31:0] irq_status_r;
  logic [31:0] irq_mask_r;
  logic [31:0] rdata_nxt;
  logic        addr_hit;
  logic [31:0] byte_mask;
  logic [31:0] eff_en_nxt;
  logic [31:0] fault_hits;
  logic        auto_clock_gating_sel;
  rcg_pmode_e  pmode;
  rcg_apb_e    apb_state_r;
  logic        wr_commit;
  logic        wr_run_gate;
  logic        wr_sleep_gate;
  logic        wr_dsleep_gate;
  logic        wr_run_cfg;
  logic        wr_irq_status;
  logic        wr_irq_mask;
  logic [31:0] irq_set;
  logic [31:0] irq_clr;
  logic [31:0] irq_status_nxt;
  logic        irq_nxt;

  // Named views of the registered effective enable bits in unit_clk_en
  logic comparator_2_clk_en;
  logic comparator_1_clk_en;
  logic comparator_0_clk_en;
  logic gp_timer_3_clk_en;
  logic gp_timer_2_clk_en;
  logic gp_timer_1_clk_en;
  logic gp_timer_0_clk_en;
  logic two_wire_1_clk_en;
  logic two_wire_0_clk_en;
  logic quad_encoder_0_clk_en;
  logic sync_serial_1_clk_en;
  logic sync_serial_0_clk_en;
  logic async_serial_2_clk_en;
  logic async_serial_1_clk_en;
  logic async_serial_0_clk_en;

  assign comparator_2_clk_en   = unit_clk_en[BIT_COMPARATOR_2];
  assign comparator_1_clk_en   = unit_clk_en[BIT_COMPARATOR_1];
  assign comparator_0_clk_en   = unit_clk_en[BIT_COMPARATOR_0];
  assign gp_timer_3_clk_en     = unit_clk_en[BIT_GP_TIMER_3];
  assign gp_timer_2_clk_en     = unit_clk_en[BIT_GP_TIMER_2];
  assign gp_timer_1_clk_en     = unit_clk_en[BIT_GP_TIMER_1];
  assign gp_timer_0_clk_en     = unit_clk_en[BIT_GP_TIMER_0];
  assign two_wire_1_clk_en     = unit_clk_en[BIT_TWO_WIRE_1];
  assign two_wire_0_clk_en     = unit_clk_en[BIT_TWO_WIRE_0];
  assign quad_encoder_0_clk_en = unit_clk_en[BIT_QUAD_ENC_0];
  assign sync_serial_1_clk_en  = unit_clk_en[BIT_SYNC_SER_1];
  assign sync_serial_0_clk_en  = unit_clk_en[BIT_SYNC_SER_0];
  assign async_serial_2_clk_en = unit_clk_en[BIT_ASYNC_SER_2];
  assign async_serial_1_clk_en = unit_clk_en[BIT_ASYNC_SER_1];
  assign async_serial_0_clk_en = unit_clk_en[BIT_ASYNC_SER_0];

  // ---------------------------------------------------------------
  // APB handshake
  // ---------------------------------------------------------------
  // Two wait states: read data is captured into a flop at the same edge that raises pready.
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      apb_state_r <= RCG_APB_IDLE;
    end else begin
      case (apb_state_r)
        RCG_APB_IDLE: begin
          if (psel && penable) begin
            apb_state_r <= RCG_APB_CAPT;
          end
        end
        RCG_APB_CAPT: begin
          apb_state_r <= RCG_APB_RESP;
        end
        RCG_APB_RESP: begin
          apb_state_r <= RCG_APB_IDLE;
        end
        default: begin
          apb_state_r <= RCG_APB_IDLE;
        end
      endcase
    end
  end

  assign pready    = (apb_state_r == RCG_APB_RESP);
  assign wr_commit = pready && psel && penable && pwrite && addr_hit;

  // Per-register strobes, all taken at the one edge that sees pready
  assign wr_run_gate    = wr_commit && (paddr == OFS_RUN_GATE_1);
  assign wr_sleep_gate  = wr_commit && (paddr == OFS_SLEEP_GATE_1);
  assign wr_dsleep_gate = wr_commit && (paddr == OFS_DSLEEP_GATE_1);
  assign wr_run_cfg     = wr_commit && (paddr == OFS_RUN_CLOCK_CFG);
  assign wr_irq_status  = wr_commit && (paddr == OFS_IRQ_STATUS);
  assign wr_irq_mask    = wr_commit && (paddr == OFS_IRQ_MASK);

  always_comb begin
    byte_mask = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      byte_mask[b*8 +: 8] = {8{pstrb[b]}};
    end
  end

  // ---------------------------------------------------------------
  // Address decode and read mux
  // ---------------------------------------------------------------
  always_comb begin
    addr_hit  = 1'b1;
    rdata_nxt = 32'h00000000;
    if (paddr == OFS_RUN_GATE_1) begin
      rdata_nxt = run_gate_reg_1_r;
    end else if (paddr == OFS_SLEEP_GATE_1) begin
      rdata_nxt = sleep_gate_reg_1_r;
    end else if (paddr == OFS_DSLEEP_GATE_1) begin
      rdata_nxt = deep_sleep_gate_reg_1_r;
    end else if (paddr == OFS_RUN_CLOCK_CFG) begin
      rdata_nxt = run_clock_config_reg_r;
    end else if (paddr == OFS_IRQ_STATUS) begin
      rdata_nxt = irq_status_r;
    end else if (paddr == OFS_IRQ_MASK) begin
      rdata_nxt = irq_mask_r;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_state_r == RCG_APB_CAPT) begin
      prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
      pslverr <= !addr_hit;
    end else if (apb_state_r == RCG_APB_RESP) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Gating registers
  // ---------------------------------------------------------------
  // Reserved bits are masked off on write so they always read zero.
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      run_gate_reg_1_r <= GATE_RESET;
    end else if (wr_run_gate) begin
      run_gate_reg_1_r <= ((pwdata & byte_mask) | (run_gate_reg_1_r & ~byte_mask))
                          & GATE_WRITABLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sleep_gate_reg_1_r <= GATE_RESET;
    end else if (wr_sleep_gate) begin
      sleep_gate_reg_1_r <= ((pwdata & byte_mask) | (sleep_gate_reg_1_r & ~byte_mask))
                            & GATE_WRITABLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      deep_sleep_gate_reg_1_r <= GATE_RESET;
    end else if (wr_dsleep_gate) begin
      deep_sleep_gate_reg_1_r <= ((pwdata & byte_mask) | (deep_sleep_gate_reg_1_r & ~byte_mask))
                                 & GATE_WRITABLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      run_clock_config_reg_r <= RCC_RESET;
    end else if (wr_run_cfg) begin
      run_clock_config_reg_r <= ((pwdata & byte_mask) | (run_clock_config_reg_r & ~byte_mask))
                                & RCC_WRITABLE;
    end
  end

  // ---------------------------------------------------------------
  // Gating source selection
  // ---------------------------------------------------------------
  assign auto_clock_gating_sel = run_clock_config_reg_r[BIT_AUTO_CLK_GATE];

  // Deep sleep outranks sleep should the core report both
  always_comb begin
    pmode = RCG_PM_RUN;
    if (auto_clock_gating_sel && core_deep_sleep) begin
      pmode = RCG_PM_DSLEEP;
    end else if (auto_clock_gating_sel && core_sleep) begin
      pmode = RCG_PM_SLEEP;
    end
  end

  always_comb begin
    case (pmode)
      RCG_PM_SLEEP:  eff_en_nxt = sleep_gate_reg_1_r;
      RCG_PM_DSLEEP: eff_en_nxt = deep_sleep_gate_reg_1_r;
      default:       eff_en_nxt = run_gate_reg_1_r;
    endcase
  end

  // Registered so the gating cells see one clean edge per change
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      unit_clk_en <= GATE_RESET;
    end else begin
      unit_clk_en <= eff_en_nxt & GATE_WRITABLE;
    end
  end

  // ---------------------------------------------------------------
  // Gated clocks
  // ---------------------------------------------------------------
  // Gating cells live in their own module so the latch style stays in one place
  rcg_gate_if u_gif (
    .sys_clk (sys_clk)
  );

  assign u_gif.clk_en = unit_clk_en;
  assign unit_clk     = u_gif.gated_clk;

  rcg_clk_gate #(
    .UNIT_MAP (GATE_WRITABLE)
  ) u_gate (
    .gif (u_gif)
  );

  // ---------------------------------------------------------------
  // Access filter
  // ---------------------------------------------------------------
  // An unclocked unit cannot answer, so the fault is raised here.
  // Reserved positions are never clocked and fault as well.
  assign fault_hits     = unit_sel & ~unit_clk_en;
  assign unit_fault     = unit_enable && (fault_hits != 32'h00000000);
  assign unit_sel_gated = unit_sel & unit_clk_en;

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  // A fault in the same cycle as a write-one-to-clear stays set.
  assign irq_set        = unit_enable ? fault_hits : 32'h00000000;
  assign irq_clr        = wr_irq_status ? (pwdata & byte_mask) : 32'h00000000;
  assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;
  // Registered so the line never glitches while status and mask settle
  assign irq_nxt        = (irq_status_r & irq_mask_r) != 32'h00000000;

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_status_r <= IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_mask_r <= IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_r <= (pwdata & byte_mask) | (irq_mask_r & ~byte_mask);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

endmodule : rcg_top
`default_nettype wire

// [test/rcg_top_props.sv]
`default_nettype none
module rcg_top_props (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_sleep,
  input wire logic        core_deep_sleep,
  input wire logic [31:0] unit_sel,
  input wire logic        unit_enable,
  input wire logic [31:0] unit_sel_gated,
  input wire logic        unit_fault,
  input wire logic [31:0] unit_clk,
  input wire logic [31:0] unit_clk_en,
  input wire logic        irq
);
  import rcg_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_fault; unit_enable && |(unit_sel & ~unit_clk_en) |-> unit_fault; endproperty
  a_fault: assert property (p_fault) else $error("gated unit access not faulted");
  property p_pass; unit_enable && |unit_sel && !(|(unit_sel & ~unit_clk_en)) |-> !unit_fault; endproperty
  a_pass: assert property (p_pass) else $error("clocked unit access faulted");
  property p_gsel; unit_sel_gated == (unit_sel & unit_clk_en); endproperty
  a_gsel: assert property (p_gsel) else $error("select reaches unclocked unit");
  property p_rsv_en; (unit_clk_en & ~GATE_WRITABLE) == 32'h0; endproperty
  a_rsv_en: assert property (p_rsv_en) else $error("enable on reserved position");
  // High phase shows the latched enable; reserved clocks must never pulse
  property p_rsv_clk; @(negedge sys_clk) (unit_clk & ~GATE_WRITABLE) == 32'h0; endproperty
  a_rsv_clk: assert property (p_rsv_clk) else $error("reserved clock pulsed");
  property p_wait; psel && $rose(penable) |-> !pready ##1 !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("register answer not after two waits");
  property p_rsv_rd; pready && !pwrite && !pslverr && paddr == OFS_RUN_GATE_1 |-> (prdata & ~GATE_WRITABLE) == 0;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved bits read nonzero");
  property p_wr_en;
    pready && pwrite && !pslverr && paddr == OFS_RUN_GATE_1 && pstrb == 4'hf && !core_sleep && !core_deep_sleep
    ##1 !core_sleep && !core_deep_sleep |-> ##1 unit_clk_en == ($past(pwdata, 2) & GATE_WRITABLE);
  endproperty
  a_wr_en: assert property (p_wr_en) else $error("run gate write not applied");
  c_fault: cover property (unit_enable && unit_fault);
  c_wr: cover property (pready && pwrite && paddr == OFS_RUN_GATE_1);
  c_irq: cover property ($rose(irq));
endmodule : rcg_top_props
bind rcg_top rcg_top_props u_props (
  .sys_clk (sys_clk), .resetn (resetn), .psel (psel), .penable (penable), .pwrite (pwrite),
  .paddr (paddr), .pwdata (pwdata), .pstrb (pstrb), .prdata (prdata), .pready (pready),
  .pslverr (pslverr), .core_sleep (core_sleep), .core_deep_sleep (core_deep_sleep),
  .unit_sel (unit_sel), .unit_enable (unit_enable), .unit_sel_gated (unit_sel_gated),
  .unit_fault (unit_fault), .unit_clk (unit_clk), .unit_clk_en (unit_clk_en), .irq (irq)
);
`default_nettype wire

// [test/rcg_unit_model.sv]
`default_nettype none
module rcg_unit_model (
  input  wire logic [31:0] unit_clk,
  output var  logic [31:0] beat
);
  timeunit 1ns;
  timeprecision 1ns;
  // A unit only advances on its own gated clock, so a missing pulse shows
  for (genvar i = 0; i < 32; i++) begin : g_unit
    initial beat[i] = 1'b0;
    always @(posedge unit_clk[i]) beat[i] <= ~beat[i];
  end
endmodule : rcg_unit_model
`default_nettype wire

// [test/rcg_top_tb_top.sv]
`default_nettype none
module rcg_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, unit_sel = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        core_sleep = 1'b0, core_deep_sleep = 1'b0, unit_enable = 1'b0;
  logic [31:0] prdata, unit_sel_gated, unit_clk, unit_clk_en, beat, rd;
  logic        pready, pslverr, unit_fault, irq, er;
  int          err_total = 0, cmp_count = 0, cyc = 0;
  int          bits[15] = '{26, 25, 24, 19, 18, 17, 16, 14, 12, 8, 5, 4, 2, 1, 0};

  always #50 sys_clk = ~sys_clk;
  rcg_top DUT (
    .sys_clk (sys_clk), .resetn (resetn), .psel (psel), .penable (penable), .pwrite (pwrite),
    .paddr (paddr), .pwdata (pwdata), .pstrb (pstrb), .prdata (prdata), .pready (pready),
    .pslverr (pslverr), .core_sleep (core_sleep), .core_deep_sleep (core_deep_sleep),
    .unit_sel (unit_sel), .unit_enable (unit_enable), .unit_sel_gated (unit_sel_gated),
    .unit_fault (unit_fault), .unit_clk (unit_clk), .unit_clk_en (unit_clk_en), .irq (irq)
  );
  rcg_unit_model u_units (.unit_clk (unit_clk), .beat (beat));

  task automatic complete_run;
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Request stands until the rising edge that samples pready high; data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic beats(input logic [31:0] exp);
    logic [31:0] p;
    @(posedge sys_clk);
    #1 p = beat;
    @(posedge sys_clk);
    #1 check(beat ^ p, exp);
  endtask : beats

  task automatic uhit(input int b, input logic f);
    @(posedge sys_clk);
    unit_sel <= 32'h1 << b;
    unit_enable <= 1'b1;
    #1 check({31'h0, unit_fault}, {31'h0, f});
    check(unit_sel_gated, f ? 32'h0 : 32'h1 << b);
    @(posedge sys_clk);
    unit_enable <= 1'b0;
    unit_sel <= 32'h0;
  endtask : uhit

  task automatic t_reset;
    apb(1'b0, 12'h104, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h114, 32'h0);
    check(rd, 32'h0);
    beats(32'h0);
  endtask : t_reset

  task automatic t_bits;
    logic [31:0] all;
    all = 32'h0;
    foreach (bits[i]) all[bits[i]] = 1'b1;
    apb(1'b1, 12'h104, 32'hffffffff);
    apb(1'b0, 12'h104, 32'h0);
    check(rd, all);
    foreach (bits[i]) begin
      apb(1'b1, 12'h104, 32'h1 << bits[i]);
      settle();
      beats(32'h1 << bits[i]);
      uhit(bits[i], 1'b0);
      uhit(3, 1'b1);
    end
  endtask : t_bits

  task automatic t_irq;
    apb(1'b1, 12'h104, 32'h0);
    apb(1'b1, 12'h204, 32'h1);
    uhit(0, 1'b1);
    settle();
    check({31'h0, irq}, 32'h1);
    uhit(1, 1'b1);
    apb(1'b0, 12'h200, 32'h0);
    // Bit 3 still stands from the reserved-slot faults of the bit walk
    check(rd, 32'hb);
    apb(1'b1, 12'h200, 32'h1);
    settle();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h104, 32'h1);
    settle();
    uhit(0, 1'b0);
  endtask : t_irq

  task automatic t_sleep;
    apb(1'b1, 12'h114, 32'h2);
    apb(1'b1, 12'h124, 32'h4);
    @(posedge sys_clk);
    core_sleep <= 1'b1;
    settle();
    check(unit_clk_en, 32'h1);
    apb(1'b1, 12'h060, 32'h1 << 27);
    settle();
    check(unit_clk_en, 32'h2);
    beats(32'h2);
    @(posedge sys_clk);
    core_deep_sleep <= 1'b1;
    settle();
    check(unit_clk_en, 32'h4);
    @(posedge sys_clk);
    core_sleep <= 1'b0;
    core_deep_sleep <= 1'b0;
    settle();
    check(unit_clk_en, 32'h1);
  endtask : t_sleep

  task automatic t_unmapped;
    apb(1'b1, 12'h300, 32'hffffffff);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 12'h104, 32'h0);
    check(rd, 32'h1);
  endtask : t_unmapped

  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_bits();
    t_irq();
    t_sleep();
    t_unmapped();
    complete_run();
  end
endmodule : rcg_top_tb_top
`default_nettype wire
